// File: src/spsc_regs.sv
// banked register slice: port-two status, host-port control and per-frame host-port decisions
`timescale 1ns/1ns
module spsc_regs #(
	parameter int ADDR_W = 4
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [spsc_pkg::DW-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [spsc_pkg::DW-1:0] rdata,
	input wire spsc_pkg::spsc_phy_t phy,
	input wire spsc_pkg::spsc_rx_t rx_req,
	output spsc_pkg::spsc_rxd_t rx_dec,
	input wire spsc_pkg::spsc_tx_t tx_req,
	output spsc_pkg::spsc_txd_t tx_dec,
	output logic crossover_scheme_select,
	output logic [spsc_pkg::BW-1:0] bank,
	output logic [spsc_pkg::DW-1:0] host_port_control_one,
	output logic [spsc_pkg::DW-1:0] host_port_control_two,
	output logic [spsc_pkg::DW-1:0] host_port_vlan_id_control,
	output logic [spsc_pkg::DW-1:0] host_port_control_three,
	output logic [spsc_pkg::DW-1:0] host_port_ingress_rate,
	output logic [spsc_pkg::DW-1:0] host_port_egress_rate
);
	import spsc_pkg::*;

	if (ADDR_W != AW) begin : g_chk
		$error("spsc_regs: ADDR_W must equal the register offset width");
	end

	////////////////////////////////////////////////////////////////////////////
	// decode

	function automatic logic hit(input logic [BW-1:0] b, input logic [AW-1:0] a,
		input logic [BW-1:0] wb, input logic [AW-1:0] wa);
		return (b == wb) && (a == wa);
	endfunction

	// offsets only mean something in the two mapped banks; bank select answers anywhere
	wire logic [AW-1:0] off = addr[AW-1:0];
	wire logic at_bank = off == OFS_BANK;
	wire logic at_stat = hit(bank, off, BANK_P2, OFS_STAT);
	wire logic at_ctl1 = hit(bank, off, BANK_HOST, OFS_CTL1);
	wire logic at_ctl2 = hit(bank, off, BANK_HOST, OFS_CTL2);
	wire logic at_vid = hit(bank, off, BANK_HOST, OFS_VID);
	wire logic at_ctl3 = hit(bank, off, BANK_HOST, OFS_CTL3);
	wire logic at_irate = hit(bank, off, BANK_HOST, OFS_IRATE);
	wire logic at_erate = hit(bank, off, BANK_HOST, OFS_ERATE);

	////////////////////////////////////////////////////////////////////////////
	// port-two status word; only the mode bit is stored, the rest is live

	wire logic [DW-1:0] stat_word = {
		crossover_scheme_select,
		1'b0,
		phy.rx_pol_rev,
		phy.rx_fc,
		phy.tx_fc,
		phy.speed100,
		phy.full_dpx,
		1'b0,
		phy.mdi,
		phy.an_done,
		phy.link_good,
		phy.partner
	};

	////////////////////////////////////////////////////////////////////////////
	// register writes

	// the bank select answers in every bank, reserved ones included
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bank <= BANK_RST;
		end else if (wr && at_bank) begin
			bank <= wdata[BW-1:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			crossover_scheme_select <= ST_MODE_RST;
		end else if (wr && at_stat) begin
			crossover_scheme_select <= wdata[ST_MODE];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			host_port_control_two <= C2_RST;
		end else if (wr && at_ctl2) begin
			// masking at the write keeps reserved bits from ever reading back as one
			host_port_control_two <= wdata & C2_WMASK;
		end
	end

	// the layouts of these words live elsewhere, so every bit is kept
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			host_port_control_one <= REG_RST;
		end else if (wr && at_ctl1) begin
			host_port_control_one <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			host_port_vlan_id_control <= REG_RST;
		end else if (wr && at_vid) begin
			host_port_vlan_id_control <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			host_port_control_three <= REG_RST;
		end else if (wr && at_ctl3) begin
			host_port_control_three <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			host_port_ingress_rate <= REG_RST;
		end else if (wr && at_irate) begin
			host_port_ingress_rate <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			host_port_egress_rate <= REG_RST;
		end else if (wr && at_erate) begin
			host_port_egress_rate <= wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register reads; anything unmapped reads zero

	wire logic [DW-1:0] bank_word = {{(DW-BW){1'b0}}, bank};
	wire logic [DW-1:0] next_rdata =
		at_bank ? bank_word :
		at_stat ? stat_word :
		at_ctl1 ? host_port_control_one :
		at_ctl2 ? host_port_control_two :
		at_vid ? host_port_vlan_id_control :
		at_ctl3 ? host_port_control_three :
		at_irate ? host_port_ingress_rate :
		at_erate ? host_port_egress_rate :
		REG_RST;

	// data stand for the cycle after the strobe only
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= REG_RST;
		end else begin
			rdata <= rd ? next_rdata : REG_RST;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receive decision for frames arriving on the host port

	wire logic [DW-1:0] c2 = host_port_control_two;
	wire logic [2:0] memb = c2[C2_MEMB_HI:0];
	wire logic [TAG_VID_HI:0] port_default_vlan_id = host_port_vlan_id_control[TAG_VID_HI:0];
	wire logic [2:0] def_prio = host_port_vlan_id_control[TAG_PRIO_HI:TAG_PRIO_LO];

	// every drop reason folds into one flag so learn, monitor and fwd agree
	wire logic vlan_drop = c2[C2_VFILT] && !rx_req.members[PORT_HOST];
	wire logic port_default_vlan_id_drop = c2[C2_NPVID]
		&& (rx_req.vlan_identifier != port_default_vlan_id);
	wire logic rx_drop = !c2[C2_RXEN] || vlan_drop || port_default_vlan_id_drop;
	wire logic ceil_hit = c2[C2_CEIL] && (rx_req.prio > def_prio);
	// never send a frame back out the port it came in on
	wire logic [2:0] host_mask = 3'h3;
	wire logic [2:0] next_fwd = rx_drop ? 3'h0 : (rx_req.dest & memb & host_mask);

	spsc_rxd_t next_rx_dec;
	assign next_rx_dec.valid = rx_req.valid;
	assign next_rx_dec.drop = rx_req.valid && rx_drop;
	assign next_rx_dec.learn = rx_req.valid && !rx_drop && !c2[C2_NOLRN];
	assign next_rx_dec.monitor = rx_req.valid && !rx_drop && c2[C2_RXSN];
	assign next_rx_dec.fwd = rx_req.valid ? next_fwd : 3'h0;
	assign next_rx_dec.prio = ceil_hit ? def_prio : rx_req.prio;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_dec <= '0;
		end else begin
			rx_dec <= next_rx_dec;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transmit decision for frames leaving on the host port

	// transmit enable overrides everything, monitor duty included
	wire logic tx_want = tx_req.to_host || (tx_req.monitored && c2[C2_SNIFP]);
	spsc_txd_t next_tx_dec;
	assign next_tx_dec.valid = tx_req.valid;
	assign next_tx_dec.send = tx_req.valid && c2[C2_TXEN] && tx_want;
	assign next_tx_dec.mark = next_tx_dec.send && c2[C2_TXSN];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_dec <= '0;
		end else begin
			tx_dec <= next_tx_dec;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	// all checks run on the one clock and go quiet while reset is held
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	mode_write_a: assert property (wr && at_stat |=>
		crossover_scheme_select == $past(wdata[ST_MODE]))
		else $error("crossover mode bit did not take the write");

	stat_read_a: assert property (rd && at_stat |=>
		rdata[ST_POL] == $past(phy.rx_pol_rev) && rdata[ST_SPD] == $past(phy.speed100)
		&& rdata[ST_DPX] == $past(phy.full_dpx) && rdata[4:0] == $past(phy.partner))
		else $error("status word does not mirror the link state");

	// a read right behind may legally refill rdata, so only an idle cycle must read zero
	stat_resv_a: assert property (rd && at_stat |=>
		rdata[14] == 1'b0 && rdata[8] == 1'b0 ##1 ($past(rd) || rdata == REG_RST))
		else $error("reserved status bits or stale read data");

	stat_flow_a: assert property (rd && at_stat |=>
		rdata[ST_RXFC] == $past(phy.rx_fc) && rdata[ST_TXFC] == $past(phy.tx_fc)
		&& rdata[ST_MODE] == $past(crossover_scheme_select))
		else $error("flow control or mode bit misreported");

	vlan_filt_a: assert property (rx_req.valid && c2[C2_VFILT]
		&& !rx_req.members[PORT_HOST] |=> rx_dec.drop && rx_dec.fwd == 3'h0)
		else $error("frame outside table membership not dropped");

	port_default_vlan_id_drop_a: assert property (rx_req.valid && c2[C2_NPVID]
		&& rx_req.vlan_identifier != port_default_vlan_id |=> rx_dec.drop)
		else $error("frame with foreign tag not dropped");

	rx_gate_a: assert property (rx_req.valid && !c2[C2_RXEN] |=>
		rx_dec.drop && !rx_dec.learn && !rx_dec.monitor)
		else $error("frame accepted while reception is off");

	tx_gate_a: assert property (tx_dec.send |-> $past(c2[C2_TXEN])
		&& $past(tx_req.valid))
		else $error("frame sent while transmission is off");

	learn_off_a: assert property (rx_dec.learn |-> !$past(c2[C2_NOLRN]))
		else $error("address learned while learning is disabled");

	fwd_memb_a: assert property (rx_dec.valid |->
		(rx_dec.fwd & ~$past(memb)) == 3'h0)
		else $error("frame forwarded outside the membership");

	prio_ceil_a: assert property (rx_dec.valid && $past(c2[C2_CEIL]) |->
		rx_dec.prio <= $past(def_prio))
		else $error("priority above the default tag ceiling");

	sniff_tx_a: assert property (tx_req.valid && tx_req.monitored && c2[C2_SNIFP]
		&& c2[C2_TXEN] |=> tx_dec.send)
		else $error("monitor port did not send monitored frame");

	bank_any_a: assert property (wr && at_bank |=> bank == $past(wdata[BW-1:0]))
		else $error("bank select write lost");

	// the decision checks below compare against the request one cycle back
	rx_pass_a: assert property (rx_req.valid && c2[C2_RXEN] && !c2[C2_VFILT]
		&& !c2[C2_NPVID] |=> rx_dec.valid && !rx_dec.drop)
		else $error("frame refused while reception is on");

	learn_on_a: assert property (rx_req.valid && !rx_drop && !c2[C2_NOLRN] |=>
		rx_dec.learn)
		else $error("address not learned while learning is on");

	rx_sniff_a: assert property (rx_req.valid && !rx_drop && c2[C2_RXSN] |=>
		rx_dec.monitor)
		else $error("received frame not marked for monitoring");

	member_fwd_a: assert property (rx_req.valid && !rx_drop && memb[PORT_ONE]
		&& rx_req.dest[PORT_ONE] |=> rx_dec.fwd[PORT_ONE])
		else $error("frame withheld from a member port");

	host_loop_a: assert property (rx_dec.valid |-> !rx_dec.fwd[PORT_HOST])
		else $error("frame sent back to the host port");

	prio_keep_a: assert property (rx_dec.valid && !$past(c2[C2_CEIL]) |->
		rx_dec.prio == $past(rx_req.prio))
		else $error("priority changed while the ceiling is off");

	tx_on_a: assert property (tx_req.valid && tx_req.to_host && c2[C2_TXEN] |=>
		tx_dec.send)
		else $error("frame held back while transmission is on");

	tx_off_a: assert property (tx_req.valid && !c2[C2_TXEN] |=>
		!tx_dec.send && !tx_dec.mark)
		else $error("frame sent while transmission is off");

	tx_sniff_a: assert property (tx_dec.send |->
		tx_dec.mark == $past(c2[C2_TXSN]))
		else $error("sent frame marking does not follow transmit sniff");

	ctl2_resv_a: assert property ((host_port_control_two & ~C2_WMASK) == REG_RST)
		else $error("reserved control bits set");

	// reserved banks above the host bank must stay silent even at the status and control offsets
	bank_resv_a: assert property (rd && !at_bank && bank > BANK_HOST |=>
		rdata == REG_RST)
		else $error("reserved bank returned data");

	rx_drop_c: cover property (rx_req.valid && rx_drop ##1 rx_dec.drop);
	rx_mon_c: cover property (rx_dec.monitor && rx_dec.fwd != 3'h0);
	tx_mark_c: cover property (tx_dec.mark);
	ctl2_rw_c: cover property (wr && at_ctl2 ##1 rd && at_ctl2);
	bank_resv_c: cover property (wr && at_bank ##1 bank > BANK_HOST);

endmodule

// File: src/spsc_pkg.sv
// shared constants, register layout and carrier types of the port status and host control slice
package spsc_pkg;

	localparam int AW = 4;
	localparam int DW = 16;
	localparam int BW = 6;

	localparam logic [AW-1:0] OFS_CTL1 = 4'h0;
	localparam logic [AW-1:0] OFS_CTL2 = 4'h2;
	localparam logic [AW-1:0] OFS_STAT = 4'h4;
	localparam logic [AW-1:0] OFS_VID = 4'h4;
	localparam logic [AW-1:0] OFS_CTL3 = 4'h6;
	localparam logic [AW-1:0] OFS_IRATE = 4'h8;
	localparam logic [AW-1:0] OFS_ERATE = 4'hA;
	localparam logic [AW-1:0] OFS_BANK = 4'hE;

	localparam logic [BW-1:0] BANK_P2 = 6'h33;
	localparam logic [BW-1:0] BANK_HOST = 6'h34;
	localparam logic [BW-1:0] BANK_RST = 6'h00;

	localparam int ST_MODE = 15;
	localparam int ST_POL = 13;
	localparam int ST_RXFC = 12;
	localparam int ST_TXFC = 11;
	localparam int ST_SPD = 10;
	localparam int ST_DPX = 9;
	localparam int ST_MDI = 7;
	localparam int ST_AN = 6;
	localparam int ST_LINK = 5;
	localparam int ST_PART_HI = 4;
	localparam logic ST_MODE_RST = 1'b1;

	localparam int C2_VFILT = 14;
	localparam int C2_NPVID = 13;
	localparam int C2_TXEN = 10;
	localparam int C2_RXEN = 9;
	localparam int C2_NOLRN = 8;
	localparam int C2_SNIFP = 7;
	localparam int C2_RXSN = 6;
	localparam int C2_TXSN = 5;
	localparam int C2_CEIL = 3;
	localparam int C2_MEMB_HI = 2;
	localparam logic [DW-1:0] C2_RST = 16'h0607;
	localparam logic [DW-1:0] C2_WMASK = 16'h67EF;
	localparam logic [DW-1:0] REG_RST = 16'h0000;

	localparam int TAG_PRIO_HI = 15;
	localparam int TAG_PRIO_LO = 13;
	localparam int TAG_VID_HI = 11;

	localparam int PORT_ONE = 0;
	localparam int PORT_TWO = 1;
	localparam int PORT_HOST = 2;

	typedef struct packed {
		logic rx_pol_rev;
		logic rx_fc;
		logic tx_fc;
		logic speed100;
		logic full_dpx;
		logic mdi;
		logic an_done;
		logic link_good;
		logic [4:0] partner;
	} spsc_phy_t;

	typedef struct packed {
		logic valid;
		logic [2:0] members;
		logic [11:0] vlan_identifier;
		logic [2:0] prio;
		logic [2:0] dest;
	} spsc_rx_t;

	typedef struct packed {
		logic valid;
		logic drop;
		logic learn;
		logic monitor;
		logic [2:0] fwd;
		logic [2:0] prio;
	} spsc_rxd_t;

	typedef struct packed {
		logic valid;
		logic to_host;
		logic monitored;
	} spsc_tx_t;

	typedef struct packed {
		logic valid;
		logic send;
		logic mark;
	} spsc_txd_t;

endpackage

// File: dv/testbench.sv
// self-checking bench for the port status and host control register slice
`timescale 1ns/1ns
module testbench;
	import spsc_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	spsc_phy_t phy = '0;
	spsc_rx_t rx_req = '0;
	spsc_rxd_t rx_dec;
	spsc_tx_t tx_req = '0;
	spsc_txd_t tx_dec;
	logic xsel;
	logic [5:0] bank;
	logic [15:0] c1, c2, vc, c3, ir, er;
	int err_total = 0;
	int samples_checked = 0;
	int cycles = 0;
	// lfsr starts at 70473
	logic [31:0] seed = 32'h00011349;
	logic [15:0] v, w, vcs, c2s;
	logic m;
	logic [3:0] a;
	spsc_rx_t q;
	spsc_tx_t tq;

	always #5 clk = ~clk;

	spsc_regs #(.ADDR_W(4)) i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .phy(phy), .rx_req(rx_req), .rx_dec(rx_dec),
		.tx_req(tx_req), .tx_dec(tx_dec), .crossover_scheme_select(xsel), .bank(bank),
		.host_port_control_one(c1), .host_port_control_two(c2),
		.host_port_vlan_id_control(vc), .host_port_control_three(c3),
		.host_port_ingress_rate(ir), .host_port_egress_rate(er));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
	endfunction

	function automatic logic [15:0] st_exp(input logic md, input spsc_phy_t p);
		return {md, 1'b0, p.rx_pol_rev, p.rx_fc, p.tx_fc, p.speed100, p.full_dpx, 1'b0,
			p.mdi, p.an_done, p.link_good, p.partner};
	endfunction

	// host-ingress frames never go back to the host, so bit 2 of the mask is ignored
	function automatic spsc_rxd_t rx_exp(input logic [15:0] cr, input logic [15:0] vr,
		input spsc_rx_t f);
		logic dr;
		dr = !cr[9] || (cr[14] && !f.members[2]) || (cr[13] && f.vlan_identifier != vr[11:0]);
		rx_exp.valid = 1'b1;
		rx_exp.drop = dr;
		rx_exp.learn = !dr && !cr[8];
		rx_exp.monitor = !dr && cr[6];
		rx_exp.fwd = dr ? 3'h0 : (f.dest & cr[2:0] & 3'h3);
		rx_exp.prio = (cr[3] && f.prio > vr[15:13]) ? vr[15:13] : f.prio;
	endfunction

	function automatic spsc_txd_t tx_exp(input logic [15:0] cr, input spsc_tx_t f);
		tx_exp.valid = 1'b1;
		tx_exp.send = cr[10] && (f.to_host || (f.monitored && cr[7]));
		tx_exp.mark = tx_exp.send && cr[5];
	endfunction

	task automatic rnd(output logic [15:0] r);
		seed = lfsr(seed);
		r = seed[15:0];
	endtask

	task automatic end_sim();
		$display("counts: %0d checked, %0d mismatches", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wreg(input logic [3:0] ad, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= ad;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rreg(input logic [3:0] ad, output logic [15:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= ad;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			$display("timeout reached");
			end_sim();
		end
	end

	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		rreg(OFS_BANK, v);
		chk(v, 16'h0000);
		wreg(OFS_BANK, {10'h000, BANK_P2});
		rreg(OFS_STAT, v);
		chk(v, 16'h8000);
		chk({15'h0000, xsel}, 16'h0001);
		for (int i = 0; i < 12; i++) begin
			rnd(v);
			if (i < 2) begin
				v = (i == 0) ? 16'h0000 : 16'hFFFF;
			end
			@(posedge clk);
			phy <= v[12:0];
			rnd(w);
			wreg(OFS_STAT, v ^ w);
			m = v[15] ^ w[15];
			rreg(OFS_STAT, v);
			chk(v, st_exp(m, phy));
		end
		$display("test status done");
		wreg(OFS_BANK, {10'h000, BANK_HOST});
		rreg(OFS_CTL2, v);
		chk(v, C2_RST);
		for (int i = 0; i < 6; i++) begin
			a = 4'(2 * i);
			rnd(w);
			wreg(a, w);
			rreg(a, v);
			chk(v, (a == OFS_CTL2) ? (w & C2_WMASK) : w);
			v = (a == 4'h0) ? c1 : (a == 4'h2) ? c2 : (a == 4'h4) ? vc :
				(a == 4'h6) ? c3 : (a == 4'h8) ? ir : er;
			chk(v, (a == OFS_CTL2) ? (w & C2_WMASK) : w);
		end
		rreg(4'hC, v);
		chk(v, 16'h0000);
		// write then read with no gap, then the idle cycle after the read data
		@(posedge clk);
		wr <= 1'b1;
		addr <= OFS_CTL2;
		wdata <= 16'hFFFF;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, C2_WMASK);
		@(posedge clk);
		#1;
		chk(rdata, 16'h0000);
		for (int i = 0; i < 2; i++) begin
			w = (i == 0) ? 16'hFF35 : 16'h003F;
			wreg(OFS_BANK, w);
			wreg(OFS_STAT, 16'hFFFF);
			rreg(OFS_STAT, v);
			chk(v, 16'h0000);
			rreg(OFS_BANK, v);
			chk(v, w & 16'h003F);
			chk({10'h000, bank}, w & 16'h003F);
		end
		wreg(OFS_BANK, {10'h000, BANK_HOST});
		$display("test map done");
		for (int i = 0; i < 48; i++) begin
			if (i % 8 == 0) begin
				rnd(w);
				wreg(OFS_CTL2, w);
				c2s = w & C2_WMASK;
				rnd(vcs);
				wreg(OFS_VID, vcs);
			end
			rnd(v);
			rnd(w);
			q.valid = 1'b1;
			q.members = v[2:0];
			q.dest = v[5:3];
			q.prio = v[8:6];
			q.vlan_identifier = v[9] ? vcs[11:0] : w[11:0];
			tq.valid = 1'b1;
			tq.to_host = v[10];
			tq.monitored = v[11];
			@(posedge clk);
			rx_req <= q;
			tx_req <= tq;
			@(posedge clk);
			rx_req <= '0;
			tx_req <= '0;
			#1;
			chk({6'h00, rx_dec}, {6'h00, rx_exp(c2s, vcs, q)});
			chk({13'h0000, tx_dec}, {13'h0000, tx_exp(c2s, tq)});
		end
		$display("test decisions done");
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		wreg(OFS_BANK, {10'h000, BANK_HOST});
		rreg(OFS_CTL2, v);
		chk(v, C2_RST);
		chk(c2, C2_RST);
		chk({15'h0000, xsel}, 16'h0001);
		chk({10'h000, bank}, {10'h000, BANK_HOST});
		$display("test second reset done");
		end_sim();
	end
endmodule
